// ===== hdl/tpioc_top.sv
// Behaviour
// - Top bit 0 means compare; low bits pick action
// - Level bit clear: pin starts low
// - Level bit set: pin starts high
// - Field 1000 captures on rising pin edge
// - Field 1001 captures on falling pin edge
// - Field 101x captures on both pin edges
// - Channel 4 11xx captures on channel 3 event
// - Channel 5 capture ignores bit 6; pin only
// - Channel 0 field bits 3:0; 11xx counter tick
// - Channel 0 pin capture uses shared edge codes
// - Channels 4 and 5 field in bits 7:4
`timescale 1ns/1ps
`default_nettype none

module tpioc_top #(
  parameter int GR_W = 16,
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Counter values of the owning channels
  input wire logic [GR_W-1:0] chan4_count,
  input wire logic [GR_W-1:0] chan5_count,
  input wire logic [GR_W-1:0] chan0_count,
  // Internal capture sources, same clock
  input wire logic chan3_general_reg_c_event,
  input wire logic chan1_counter_tick,
  // Timer pins
  input wire logic chan4_pin_b_in,
  output tpioc_pkg::tpioc_pin_t chan4_pin_b_drive,
  input wire logic chan5_pin_b_in,
  output tpioc_pkg::tpioc_pin_t chan5_pin_b_drive,
  input wire logic chan0_pin_a_in,
  output tpioc_pkg::tpioc_pin_t chan0_pin_a_drive,
  // One-cycle pulses per slot: capture taken, compare match
  output logic [2:0] capture_pulse,
  output logic [2:0] match_pulse
);

  localparam int NCH = tpioc_pkg::TPIOC_NCH;
  localparam int FW = tpioc_pkg::TPIOC_FIELD_W;
  localparam int CW = tpioc_pkg::TPIOC_CTRL_W;

  // Raw control bytes, one per slot
  logic [CW-1:0] ctrl [NCH];
  // General registers, compare value or captured count
  logic [GR_W-1:0] general_reg [NCH];
  // Extracted 4-bit pin control fields
  logic [FW-1:0] field [NCH];
  // Counter value seen by each slot
  logic [GR_W-1:0] count [NCH];
  // Previous counter value, for match on arrival
  logic [GR_W-1:0] count_prev [NCH];
  // Pin synchroniser chains and edge history
  logic [NCH-1:0] pin_s1;
  logic [NCH-1:0] pin_s2;
  logic [NCH-1:0] pin_s3;
  logic [NCH-1:0] pin_raw;
  // Pin output levels and enables
  logic [NCH-1:0] pin_level;
  logic [NCH-1:0] pin_oe;
  // Slot owns an internal capture source
  logic [NCH-1:0] has_internal;
  // Internal source event per slot
  logic [NCH-1:0] internal_event;
  // Decoded per-slot events
  logic [NCH-1:0] cap_evt;
  logic [NCH-1:0] cmp_evt;
  // Bus decode
  logic setup_phase;
  logic wr_access;
  logic [CW-1:0] next_prdata_low;
  logic [31:0] next_prdata;
  logic next_slverr;
  logic [NCH-1:0] ctrl_hit;
  logic [NCH-1:0] gr_hit;

  // Gather pins and counters into slot arrays
  assign pin_raw[tpioc_pkg::TPIOC_CH4B] = chan4_pin_b_in;
  assign pin_raw[tpioc_pkg::TPIOC_CH5B] = chan5_pin_b_in;
  assign pin_raw[tpioc_pkg::TPIOC_CH0A] = chan0_pin_a_in;
  assign count[tpioc_pkg::TPIOC_CH4B] = chan4_count;
  assign count[tpioc_pkg::TPIOC_CH5B] = chan5_count;
  assign count[tpioc_pkg::TPIOC_CH0A] = chan0_count;

  // Field placement: B fields high nibble, channel 0 A low nibble
  assign field[tpioc_pkg::TPIOC_CH4B] =
    ctrl[tpioc_pkg::TPIOC_CH4B][tpioc_pkg::TPIOC_FIELD_LO_B +: FW];
  assign field[tpioc_pkg::TPIOC_CH5B] =
    ctrl[tpioc_pkg::TPIOC_CH5B][tpioc_pkg::TPIOC_FIELD_LO_B +: FW];
  assign field[tpioc_pkg::TPIOC_CH0A] =
    ctrl[tpioc_pkg::TPIOC_CH0A][tpioc_pkg::TPIOC_FIELD_LO_A +: FW];

  // Internal sources; channel 5 has none, so bit 6 only sets its initial pin level
  assign has_internal[tpioc_pkg::TPIOC_CH4B] = 1'b1;
  assign has_internal[tpioc_pkg::TPIOC_CH5B] = 1'b0;
  assign has_internal[tpioc_pkg::TPIOC_CH0A] = 1'b1;
  assign internal_event[tpioc_pkg::TPIOC_CH4B] =
    chan3_general_reg_c_event;
  assign internal_event[tpioc_pkg::TPIOC_CH5B] = 1'b0;
  assign internal_event[tpioc_pkg::TPIOC_CH0A] =
    chan1_counter_tick;

  // Drive outputs to the pins
  assign chan4_pin_b_drive.out = pin_level[tpioc_pkg::TPIOC_CH4B];
  assign chan4_pin_b_drive.oe = pin_oe[tpioc_pkg::TPIOC_CH4B];
  assign chan5_pin_b_drive.out = pin_level[tpioc_pkg::TPIOC_CH5B];
  assign chan5_pin_b_drive.oe = pin_oe[tpioc_pkg::TPIOC_CH5B];
  assign chan0_pin_a_drive.out = pin_level[tpioc_pkg::TPIOC_CH0A];
  assign chan0_pin_a_drive.oe = pin_oe[tpioc_pkg::TPIOC_CH0A];

  // APB phases; zero wait states, so pready stays high
  // Access lasts one cycle; read data was loaded at setup
  assign setup_phase = psel & ~penable;
  assign wr_access = psel & penable & pwrite;
  assign pready = 1'b1;

  // Address hits per slot
  always_comb begin
    ctrl_hit = '0;
    gr_hit = '0;
    ctrl_hit[tpioc_pkg::TPIOC_CH4B] =
      (paddr == ADDR_W'(tpioc_pkg::TPIOC_OFS_CHAN4_CTRL));
    ctrl_hit[tpioc_pkg::TPIOC_CH5B] =
      (paddr == ADDR_W'(tpioc_pkg::TPIOC_OFS_CHAN5_CTRL));
    ctrl_hit[tpioc_pkg::TPIOC_CH0A] =
      (paddr == ADDR_W'(tpioc_pkg::TPIOC_OFS_CHAN0_CTRL));
    gr_hit[tpioc_pkg::TPIOC_CH4B] =
      (paddr == ADDR_W'(tpioc_pkg::TPIOC_OFS_CHAN4_GRB));
    gr_hit[tpioc_pkg::TPIOC_CH5B] =
      (paddr == ADDR_W'(tpioc_pkg::TPIOC_OFS_CHAN5_GRB));
    gr_hit[tpioc_pkg::TPIOC_CH0A] =
      (paddr == ADDR_W'(tpioc_pkg::TPIOC_OFS_CHAN0_GRA));
  end

  // Read mux, sampled in the setup phase so prdata comes from a flop
  always_comb begin
    next_prdata = '0;
    next_prdata_low = '0;
    next_slverr = 1'b0;
    if (paddr == ADDR_W'(tpioc_pkg::TPIOC_OFS_PIN_STATUS)) begin
      // Synchronised pin levels, driven levels, enables
      next_prdata[2:0] = pin_s2;
      next_prdata[6:4] = pin_level;
      next_prdata[10:8] = pin_oe;
    end else if (|ctrl_hit) begin
      for (int i = 0; i < NCH; i++) begin
        if (ctrl_hit[i]) begin
          next_prdata_low = ctrl[i];
        end
      end
      next_prdata[CW-1:0] = next_prdata_low;
    end else if (|gr_hit) begin
      for (int i = 0; i < NCH; i++) begin
        if (gr_hit[i]) begin
          next_prdata[GR_W-1:0] = general_reg[i];
        end
      end
    end else begin
      // Unmapped address reads zero with an error
      next_slverr = 1'b1;
    end
  end

  // Read data and error registered on the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      prdata <= pwrite ? 32'h0000_0000 : next_prdata;
      pslverr <= next_slverr;
    end
  end

  // Pin synchronisers: s1 feeds only s2, edges use s2 against s3
  // Pins are asynchronous; s3 only keeps the edge history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // Control bytes; writes only in the access phase
  // Bits outside the field are kept as plain storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NCH; i++) begin
        ctrl[i] <= tpioc_pkg::TPIOC_CTRL_RST;
      end
    end else if (wr_access) begin
      for (int i = 0; i < NCH; i++) begin
        if (ctrl_hit[i]) begin
          ctrl[i] <= pwdata[CW-1:0];
        end
      end
    end
  end

  // Per-slot compare and capture machinery
  for (genvar g = 0; g < NCH; g++) begin : g_slot
    // Slot works as a compare register
    logic is_compare;
    // Slot takes its capture from the internal source
    logic use_internal;
    // Synchronised pin edges
    logic edge_rise;
    logic edge_fall;
    // Edges chosen by the low field bits
    logic sel_rise;
    logic sel_fall;
    // Bus write to this slot's control byte
    logic ctrl_written;
    // Compare-match action from the low field bits
    tpioc_pkg::tpioc_action_t action;

    // Mode and action from the field
    assign is_compare = ~field[g][tpioc_pkg::TPIOC_FB_MODE];
    assign action = tpioc_pkg::tpioc_action_t'(
      field[g][tpioc_pkg::TPIOC_FB_ACT_HI:tpioc_pkg::TPIOC_FB_ACT_LO]);

    // 11xx goes internal only where the slot has a source
    assign use_internal = has_internal[g] &
      field[g][tpioc_pkg::TPIOC_FB_LEVEL];

    // Edge select: 00 rising, 01 falling, 1x both
    assign sel_rise = field[g][tpioc_pkg::TPIOC_FB_ACT_HI] |
      ~field[g][tpioc_pkg::TPIOC_FB_ACT_LO];
    assign sel_fall = field[g][tpioc_pkg::TPIOC_FB_ACT_HI] |
      field[g][tpioc_pkg::TPIOC_FB_ACT_LO];
    // Both edges from settled samples, never from the first flop
    assign edge_rise = pin_s2[g] & ~pin_s3[g];
    assign edge_fall = ~pin_s2[g] & pin_s3[g];

    // Capture event from the chosen source
    assign cap_evt[g] = ~is_compare & (use_internal ? internal_event[g] :
      ((sel_rise & edge_rise) | (sel_fall & edge_fall)));

    // Match when the counter arrives at the compare value
    assign cmp_evt[g] = is_compare &
      (count[g] == general_reg[g]) & (count_prev[g] != count[g]);

    assign ctrl_written = wr_access & ctrl_hit[g];

    // Counter history for arrival detection
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        count_prev[g] <= '0;
      end else begin
        count_prev[g] <= count[g];
      end
    end

    // General register: capture beats a bus write in the same cycle
    // Losing a hardware capture costs more than losing a write
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        general_reg[g] <= GR_W'(tpioc_pkg::TPIOC_GR_RST);
      end else if (cap_evt[g]) begin
        general_reg[g] <= count[g];
      end else if (wr_access & gr_hit[g]) begin
        general_reg[g] <= pwdata[GR_W-1:0];
      end
    end

    // Pin level: initial level on field write, action on match
    // A write beats a match in the same cycle; the new field rules
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pin_level[g] <= 1'b0;
      end else if (ctrl_written) begin
        // Initial level follows the level bit of the new field
        if (g == tpioc_pkg::TPIOC_CH0A) begin
          pin_level[g] <= pwdata[tpioc_pkg::TPIOC_FIELD_LO_A +
            tpioc_pkg::TPIOC_FB_LEVEL];
        end else begin
          pin_level[g] <= pwdata[tpioc_pkg::TPIOC_FIELD_LO_B +
            tpioc_pkg::TPIOC_FB_LEVEL];
        end
      end else if (cmp_evt[g]) begin
        // Action from the low field bits
        case (action)
          tpioc_pkg::TPIOC_ACT_LOW: begin
            pin_level[g] <= 1'b0;
          end
          tpioc_pkg::TPIOC_ACT_HIGH: begin
            pin_level[g] <= 1'b1;
          end
          tpioc_pkg::TPIOC_ACT_TOGGLE: begin
            pin_level[g] <= ~pin_level[g];
          end
          default: begin
            // Output disabled, level left as it is
            pin_level[g] <= pin_level[g];
          end
        endcase
      end
    end

    // Pin enabled only in compare mode with a non-zero action
    // Oe lags the field by one edge; the new level shows first
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pin_oe[g] <= 1'b0;
      end else begin
        pin_oe[g] <= is_compare &
          (action != tpioc_pkg::TPIOC_ACT_NONE);
      end
    end

    // Event pulses for neighbouring channels
    // Registered so neighbours see a clean one-cycle pulse
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        capture_pulse[g] <= 1'b0;
        match_pulse[g] <= 1'b0;
      end else begin
        capture_pulse[g] <= cap_evt[g];
        match_pulse[g] <= cmp_evt[g];
      end
    end
  end

endmodule

`default_nettype wire

// ===== include/tpioc_pkg.sv
// Shared constants and types for the timer pin input/output control block
package tpioc_pkg;

  // Register byte offsets on the APB side
  localparam logic [7:0] TPIOC_OFS_CHAN4_CTRL = 8'h00;
  localparam logic [7:0] TPIOC_OFS_CHAN5_CTRL = 8'h04;
  localparam logic [7:0] TPIOC_OFS_CHAN0_CTRL = 8'h08;
  localparam logic [7:0] TPIOC_OFS_CHAN4_GRB = 8'h0C;
  localparam logic [7:0] TPIOC_OFS_CHAN5_GRB = 8'h10;
  localparam logic [7:0] TPIOC_OFS_CHAN0_GRA = 8'h14;
  localparam logic [7:0] TPIOC_OFS_PIN_STATUS = 8'h18;

  // Control register width and field positions
  localparam int TPIOC_CTRL_W = 8;
  localparam int TPIOC_FIELD_W = 4;
  localparam int TPIOC_FIELD_LO_B = 4;
  localparam int TPIOC_FIELD_LO_A = 0;

  // Bit positions inside a 4-bit pin control field
  localparam int TPIOC_FB_MODE = 3;
  localparam int TPIOC_FB_LEVEL = 2;
  localparam int TPIOC_FB_ACT_HI = 1;
  localparam int TPIOC_FB_ACT_LO = 0;

  // Values after reset
  localparam logic [7:0] TPIOC_CTRL_RST = 8'h00;
  localparam logic [15:0] TPIOC_GR_RST = 16'hFFFF;

  // Channel slots inside the block
  localparam int TPIOC_NCH = 3;
  localparam int TPIOC_CH4B = 0;
  localparam int TPIOC_CH5B = 1;
  localparam int TPIOC_CH0A = 2;

  // Synchroniser depth for pin inputs
  localparam int TPIOC_SYNC_STAGES = 2;

  // Compare-match action codes
  typedef enum logic [1:0] {
    TPIOC_ACT_NONE = 2'h0,
    TPIOC_ACT_LOW = 2'h1,
    TPIOC_ACT_HIGH = 2'h2,
    TPIOC_ACT_TOGGLE = 2'h3
  } tpioc_action_t;

  // Drive of one two-way timer pin
  typedef struct packed {
    logic out;
    logic oe;
  } tpioc_pin_t;

endpackage

// ===== verification/tpioc_far_side.sv
`timescale 1ns/1ps
`default_nettype none
// Far side: pin wires and a stoppable neighbour counter
module tpioc_far_side (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [2:0] ext_level,
  input wire logic [2:0] oe,
  input wire logic [2:0] out,
  output logic [2:0] pin_level,
  output logic [15:0] count
);
  // Device drive wins the wire, else the far-side level
  assign pin_level = (oe & out) | (~oe & ext_level);
  // Held still on request, so captured values are known
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 16'h0000;
    end else if (run) begin
      count <= count + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// ===== verification/tpioc_properties.sv
`timescale 1ns/1ps
`default_nettype none
// Port checks; control fields are shadowed from bus writes
module tpioc_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic chan3_general_reg_c_event,
  input wire logic chan1_counter_tick,
  input wire logic chan4_pin_b_in,
  input wire logic chan5_pin_b_in,
  input wire tpioc_pkg::tpioc_pin_t chan4_pin_b_drive,
  input wire tpioc_pkg::tpioc_pin_t chan5_pin_b_drive,
  input wire tpioc_pkg::tpioc_pin_t chan0_pin_a_drive,
  input wire logic [2:0] capture_pulse,
  input wire logic [2:0] match_pulse
);
  logic [3:0] f4, f5, f0; // Field copies per slot
  logic [2:0] cap_mode; // Capture selected
  logic [2:0] on; // Compare with output enabled
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  assign cap_mode = {f0[3], f5[3], f4[3]};
  assign on = ~cap_mode & {|f0[1:0], |f5[1:0], |f4[1:0]};
  // Shadow lands at the same edge as the write itself
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      f4 <= 4'h0;
      f5 <= 4'h0;
      f0 <= 4'h0;
    end else if (psel && penable && pwrite) begin
      if (paddr == 8'h00) f4 <= pwdata[7:4];
      if (paddr == 8'h04) f5 <= pwdata[7:4];
      if (paddr == 8'h08) f0 <= pwdata[3:0];
    end
  end
  // Control write to the channel 4 byte
  sequence s_wr4;
    psel && penable && pwrite && paddr == 8'h00;
  endsequence
  // Pin edge chosen by a field; ignored bits arrive cleared
  sequence s_edge(logic [3:0] f, logic p);
    f[3:2] == 2'h2 && ($rose(p) && (f[1] || !f[0]) ||
      $fell(p) && (f[1] || f[0]));
  endsequence
  property p_int4;
    f4[3:2] == 2'h3 && chan3_general_reg_c_event |=> capture_pulse[0];
  endproperty
  a_int4: assert property (p_int4)
    else $error("ch4 internal capture missing");
  property p_tick0;
    f0[3:2] == 2'h3 && chan1_counter_tick |=> capture_pulse[2];
  endproperty
  a_tick0: assert property (p_tick0)
    else $error("ch0 tick capture missing");
  property p_nocap;
    (capture_pulse & ~$past(cap_mode)) == 3'h0;
  endproperty
  a_nocap: assert property (p_nocap)
    else $error("capture while in compare mode");
  property p_oe;
    {chan0_pin_a_drive.oe, chan5_pin_b_drive.oe,
      chan4_pin_b_drive.oe} == $past(on);
  endproperty
  a_oe: assert property (p_oe)
    else $error("output enable wrong for field");
  property p_init4;
    s_wr4 |=> chan4_pin_b_drive.out == $past(pwdata[6]);
  endproperty
  a_init4: assert property (p_init4)
    else $error("ch4 initial level wrong");
  property p_act4;
    match_pulse[0] |-> chan4_pin_b_drive.out == ($past(f4[1:0]) == 2'h3 ?
      !$past(chan4_pin_b_drive.out) : $past(f4[1:0]) == 2'h0 ?
      $past(chan4_pin_b_drive.out) : $past(f4[1]));
  endproperty
  a_act4: assert property (p_act4)
    else $error("ch4 match action wrong");
  property p_cap4;
    s_edge(f4, chan4_pin_b_in) |-> ##3 capture_pulse[0];
  endproperty
  a_cap4: assert property (p_cap4)
    else $error("ch4 pin capture missing");
  property p_cap5;
    s_edge({f5[3], 1'b0, f5[1:0]}, chan5_pin_b_in) |-> ##3 capture_pulse[1];
  endproperty
  a_cap5: assert property (p_cap5)
    else $error("ch5 pin capture missing");
endmodule
bind tpioc_top tpioc_properties i_tpioc_properties (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .chan3_general_reg_c_event,
  .chan1_counter_tick, .chan4_pin_b_in, .chan5_pin_b_in, .chan4_pin_b_drive,
  .chan5_pin_b_drive, .chan0_pin_a_drive, .capture_pulse, .match_pulse);
`default_nettype wire

// ===== verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// Bench: slots ch4B, ch5B, ch0A in that order
module tb_top;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, run = 1'b0, ev3 = 1'b0, tick1 = 1'b0;
  logic pready, pslverr, er;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] cnt; // Neighbour counter
  logic [2:0] ext = 3'h0, pin, cap, mat;
  tpioc_pkg::tpioc_pin_t dv [3]; // Pin drives
  int err_total = 0, check_count = 0, ncap [3] = '{0, 0, 0};
  logic [7:0] ctl_a [3] = '{8'h00, 8'h04, 8'h08}; // Control offsets
  logic [7:0] gr_a [3] = '{8'h0C, 8'h10, 8'h14}; // Register offsets
  int sh [3] = '{4, 4, 0}; // Field shift
  // 100 ns clock
  always #50 pclk = ~pclk;
  tpioc_top i_tpioc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chan4_count(cnt), .chan5_count(~cnt), .chan0_count(cnt),
    .chan3_general_reg_c_event(ev3), .chan1_counter_tick(tick1),
    .chan4_pin_b_in(pin[0]), .chan4_pin_b_drive(dv[0]),
    .chan5_pin_b_in(pin[1]), .chan5_pin_b_drive(dv[1]),
    .chan0_pin_a_in(pin[2]), .chan0_pin_a_drive(dv[2]),
    .capture_pulse(cap), .match_pulse(mat));
  tpioc_far_side i_tpioc_far_side (.pclk(pclk), .presetn(presetn),
    .run(run), .ext_level(ext), .oe({dv[2].oe, dv[1].oe, dv[0].oe}),
    .out({dv[2].out, dv[1].out, dv[0].out}), .pin_level(pin), .count(cnt));
  // Tally capture pulses per slot
  always @(posedge pclk) begin
    for (int s = 0; s < 3; s++) begin
      if (cap[s] === 1'b1) ncap[s]++;
    end
  end
  // Count seen by a slot; ch5 gets the inverted counter
  function automatic logic [15:0] cv(int s, logic [15:0] v);
    return (s == 1) ? ~v : v;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One bus transfer; held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the watchdog ends an endless wait
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Reset value, status, stored bits and an unmapped place
  task automatic t_regs;
    apb(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'h0000FFFF);
    apb(1'b0, 8'h18, 32'h0);
    chk({rd[30:0], er}, 32'h0);
    apb(1'b1, 8'h04, 32'hFFFFFF0F);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h0000000F);
    apb(1'b0, 8'h1C, 32'h0);
    chk({rd[30:0], er}, 32'h1);
  endtask
  // Every compare code per slot: start level, enable, match action
  task automatic t_cmp;
    int n;
    for (int s = 0; s < 3; s++) begin
      for (int c = 0; c < 8; c++) begin
        run <= 1'b0;
        apb(1'b1, ctl_a[s], 32'(c) << sh[s]);
        repeat (2) @(posedge pclk);
        chk(32'(dv[s]), {30'h0, c[2], c[1:0] != 2'h0});
        apb(1'b1, gr_a[s], 32'(cv(s, cnt + 16'h0004)));
        run <= 1'b1;
        n = 0;
        while (mat[s] !== 1'b1 && n < 12) begin
          @(posedge pclk);
          n++;
        end
        // Match pulse seen two edges after the fourth count
        chk(32'(n), 32'h6);
        chk(32'(dv[s].out), 32'(c[1:0] == 2'h3 ? !c[2] :
          c[1:0] == 2'h0 ? c[2] : c[1]));
      end
    end
    run <= 1'b0;
  endtask
  // Internal sources, then pin edges, under capture codes 8 to 14
  task automatic t_cap;
    int e, r, f, i, b;
    for (int s = 0; s < 3; s++) begin
      for (int c = 8; c < 15; c++) begin
        e = (s == 1) ? (c & 11) : c;
        r = int'(e == 8 || e == 10 || e == 11);
        f = int'(e == 9 || e == 10 || e == 11);
        i = int'(c > 11 && s != 1);
        apb(1'b1, ctl_a[s], 32'(c) << sh[s]);
        repeat (4) @(posedge pclk);
        apb(1'b1, gr_a[s], 32'h0);
        b = ncap[s];
        ev3 <= 1'b1;
        @(posedge pclk);
        ev3 <= 1'b0;
        tick1 <= 1'b1;
        @(posedge pclk);
        tick1 <= 1'b0;
        ext[s] <= 1'b1;
        repeat (6) @(posedge pclk);
        chk(32'(ncap[s] - b), 32'(r + i));
        apb(1'b0, gr_a[s], 32'h0);
        chk(rd, (r + i) > 0 ? 32'(cv(s, cnt)) : 32'h0);
        ext[s] <= 1'b0;
        repeat (6) @(posedge pclk);
        chk(32'(ncap[s] - b), 32'(r + f + i));
      end
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Main sequence after a six-cycle reset
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_cmp();
    t_cap();
    results();
  end
  // Run needs about 920 cycles; give it over twenty times that
  initial begin
    #2000000;
    err_total++;
    results();
  end
endmodule
`default_nettype wire
